// ==== rtl/pulse_timer_pkg.sv ====
// Constants shared by the pulse width timer control and status slice.
package pulse_timer_pkg;

	// ****************************************
	// Bus geometry and register map
	// ****************************************
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 32;
	localparam logic [3:0] CS_OFFSET         = 4'h0;
	localparam logic [3:0] EVT_STATUS_OFFSET = 4'h4;
	localparam logic [3:0] EVT_MASK_OFFSET   = 4'h8;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// Control and status field positions
	// ****************************************
	localparam int unsigned ENABLE_BIT     = 7;
	localparam int unsigned IRQ_MASTER_BIT = 6;
	localparam int unsigned READY_IRQ_BIT  = 5;
	localparam int unsigned OVF_IRQ_BIT    = 4;
	localparam int unsigned SOFT_RESET_BIT = 3;
	localparam int unsigned FIRST_LOAD_BIT = 2;
	localparam int unsigned READY_FLAG_BIT = 1;
	localparam int unsigned WRAP_FLAG_BIT  = 0;
	localparam logic [7:0] CS_RESET = 8'h00;

	// ****************************************
	// Event status and mask layout
	// ****************************************
	localparam int unsigned EVT_W       = 3;
	localparam int unsigned EVT_LOAD    = 0;
	localparam int unsigned EVT_WRAP    = 1;
	localparam int unsigned EVT_DISCARD = 2;
	localparam logic [2:0] EVT_RESET = 3'h0;

endpackage : pulse_timer_pkg

// ==== rtl/axil_slave_port.sv ====
// AXI4-Lite slave handshake that turns bus transfers into register strobes.
`timescale 1ns/1ps
module axil_slave_port (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [3:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [3:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	output logic             wrStrobe,
	output logic [3:0]       wrAddr,
	output logic [31:0]      wrData,
	output logic             wrByte0,
	input  wire logic        wrErr,
	output logic             rdStrobe,
	output logic [3:0]       rdAddr,
	input  wire logic [31:0] rdData,
	input  wire logic        rdErr
);

	// A channel is held once its ready flop drops; both held with no answer pending means a write.
	assign wrStrobe = !awready && !wready && !bvalid;
	assign rdStrobe = arvalid && arready;
	assign rdAddr   = araddr;

	// Write address and data are taken in either order and kept until answered.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			wrAddr  <= 4'h0;
			wrData  <= 32'h0000_0000;
			wrByte0 <= 1'b0;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				wrAddr  <= awaddr;
			end
			if (wvalid && wready) begin
				wready  <= 1'b0;
				wrData  <= wdata;
				wrByte0 <= wstrb[0];
			end
			if (bvalid && bready) begin
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// The write answer rises one edge after both halves are held.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bvalid <= 1'b0;
			bresp  <= pulse_timer_pkg::RESP_OKAY;
		end else if (wrStrobe) begin
			bvalid <= 1'b1;
			bresp  <= wrErr ? pulse_timer_pkg::RESP_SLVERR
			                : pulse_timer_pkg::RESP_OKAY;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// Read data is sampled at the address handshake, so it answers next cycle.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= pulse_timer_pkg::RESP_OKAY;
		end else if (rdStrobe) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rdData;
			rresp   <= rdErr ? pulse_timer_pkg::RESP_SLVERR
			                 : pulse_timer_pkg::RESP_OKAY;
		end else if (rvalid && rready) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
		end
	end

endmodule : axil_slave_port

// ==== rtl/pulse_width_timer_ctrl_status.sv ====
// Control and status slice of the pulse width timer with its register bus.
`timescale 1ns/1ps

// What this block does
// [RULE1] Bit 7 enables measurement activity.
// [RULE2] Software keeps configuration steady while enabled.
// [RULE3] Bit 6 gates every interrupt request.
// [RULE4] Ready enable, master and ready flag interrupt.
// [RULE5] Bit 4 allows interrupt on overflow flag.
// [RULE6] Writing one to bit 3 soft resets.
// [RULE7] Bit 2 chooses discarding or loading first value.
// [RULE8] Ready flag sets when widths update.
// [RULE9] Ready clears on read then write zero.
// [RULE10] Overflow flag sets on counter wrap.
// [RULE11] Writing zero clears overflow; one ignored.
// [RULE12] Overflow during its clear keeps flag set.
// [RULE13] First value goes by input level.
// [RULE14] Interrupt is gated OR of enabled flags.
// [RULE15] Reset and soft reset zero the register.
module pulse_width_timer_ctrl_status (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [3:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [3:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        captureEdge,
	input  wire logic        counterWrap,
	input  wire logic        inputLevel,
	output logic             timerEnable,
	output logic             softReset,
	output logic             loadPositive,
	output logic             loadNegative,
	output logic             irq
);

	// ****************************************
	// Declarations
	// ****************************************
	logic             wrStrobe;
	logic [3:0]       wrAddr;
	logic [31:0]      wrData;
	logic             wrByte0;
	logic             wrErr;
	logic             rdStrobe;
	logic [3:0]       rdAddr;
	logic [31:0]      rdData;
	logic             rdErr;
	logic             csWrite;
	logic             csRead;
	logic             softReq;
	logic             irqMaster_r;
	logic             readyIrqEn_r;
	logic             ovfIrqEn_r;
	logic             firstLoadEn_r;
	logic             readyFlag_r;
	logic             wrapFlag_r;
	logic             readArmed_r;
	logic             firstPending_r;
	logic             takeValue;
	logic             loadPos_nxt;
	logic             loadNeg_nxt;
	logic             discard;
	logic             wrapSet;
	logic             readyClear;
	logic             wrapClear;
	logic [2:0]       evtStatus_r;
	logic [2:0]       evtMask_r;
	logic [2:0]       evtSet;
	logic             irq_nxt;
	logic [7:0]       csView;

	// ****************************************
	// Bus slave
	// ****************************************
	axil_slave_port axil_slave_port_inst (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.awaddr   (awaddr),
		.awvalid  (awvalid),
		.awready  (awready),
		.wdata    (wdata),
		.wstrb    (wstrb),
		.wvalid   (wvalid),
		.wready   (wready),
		.bresp    (bresp),
		.bvalid   (bvalid),
		.bready   (bready),
		.araddr   (araddr),
		.arvalid  (arvalid),
		.arready  (arready),
		.rdata    (rdata),
		.rresp    (rresp),
		.rvalid   (rvalid),
		.rready   (rready),
		.wrStrobe (wrStrobe),
		.wrAddr   (wrAddr),
		.wrData   (wrData),
		.wrByte0  (wrByte0),
		.wrErr    (wrErr),
		.rdStrobe (rdStrobe),
		.rdAddr   (rdAddr),
		.rdData   (rdData),
		.rdErr    (rdErr)
	);

	// Every register lives in byte lane 0; other lanes are ignored.
	assign csWrite = wrStrobe && wrByte0
	                 && wrAddr == pulse_timer_pkg::CS_OFFSET;
	assign csRead  = rdStrobe && rdAddr == pulse_timer_pkg::CS_OFFSET;
	assign softReq = csWrite && wrData[pulse_timer_pkg::SOFT_RESET_BIT]; // RULE6
	assign wrErr   = wrAddr != pulse_timer_pkg::CS_OFFSET
	                 && wrAddr != pulse_timer_pkg::EVT_STATUS_OFFSET
	                 && wrAddr != pulse_timer_pkg::EVT_MASK_OFFSET;

	// ****************************************
	// Control bits
	// ****************************************
	// A soft reset wins over the rest of the same write, so nothing survives.
	always_ff @(posedge ref_clk) begin
		if (rst || softReq) begin // RULE15
			timerEnable   <= 1'b0;
			irqMaster_r   <= 1'b0;
			readyIrqEn_r  <= 1'b0;
			ovfIrqEn_r    <= 1'b0;
			firstLoadEn_r <= 1'b0;
		end else if (csWrite) begin
			timerEnable   <= wrData[pulse_timer_pkg::ENABLE_BIT]; // RULE1
			irqMaster_r   <= wrData[pulse_timer_pkg::IRQ_MASTER_BIT];
			readyIrqEn_r  <= wrData[pulse_timer_pkg::READY_IRQ_BIT];
			ovfIrqEn_r    <= wrData[pulse_timer_pkg::OVF_IRQ_BIT];
			firstLoadEn_r <= wrData[pulse_timer_pkg::FIRST_LOAD_BIT];
		end
	end

	// One-cycle soft reset pulse for the counter and width registers.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			softReset <= 1'b0;
		end else begin
			softReset <= softReq; // RULE6
		end
	end

	// ****************************************
	// First capture after enabling
	// ****************************************
	// The first edge after a 0 to 1 enable write is marked as the first one.
	always_ff @(posedge ref_clk) begin
		if (rst || softReq) begin
			firstPending_r <= 1'b0;
		end else if (csWrite) begin
			firstPending_r <= wrData[pulse_timer_pkg::ENABLE_BIT]
			                  && (!timerEnable || firstPending_r);
		end else if (captureEdge && timerEnable) begin
			firstPending_r <= 1'b0;
		end
	end

	// The level picks the width register, for the first value and later ones.
	assign takeValue   = captureEdge && timerEnable && !softReq
	                     && (!firstPending_r || firstLoadEn_r); // RULE7
	assign loadPos_nxt = takeValue && inputLevel; // RULE13
	assign loadNeg_nxt = takeValue && !inputLevel; // RULE13
	assign discard     = captureEdge && timerEnable && !softReq
	                     && firstPending_r && !firstLoadEn_r; // RULE7

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			loadPositive <= 1'b0;
			loadNegative <= 1'b0;
		end else begin
			loadPositive <= loadPos_nxt;
			loadNegative <= loadNeg_nxt;
		end
	end

	// ****************************************
	// Ready and overflow flags
	// ****************************************
	// A read that saw the ready flag set arms the clear; any later CS write
	// uses the arm up, so one read allows one clearing write; an update landing before that write is cleared too.
	always_ff @(posedge ref_clk) begin
		if (rst || softReq) begin
			readArmed_r <= 1'b0;
		end else if (csRead && readyFlag_r) begin
			readArmed_r <= 1'b1; // RULE9
		end else if (csWrite || !readyFlag_r) begin
			readArmed_r <= 1'b0;
		end
	end

	assign readyClear = csWrite && readArmed_r && readyFlag_r
	                    && !wrData[pulse_timer_pkg::READY_FLAG_BIT]; // RULE9
	assign wrapSet    = counterWrap && timerEnable && !softReq;
	assign wrapClear  = csWrite && wrapFlag_r
	                    && !wrData[pulse_timer_pkg::WRAP_FLAG_BIT]; // RULE11

	// A new update or wrap beats a clear in the same cycle.
	always_ff @(posedge ref_clk) begin
		if (rst || softReq) begin
			readyFlag_r <= 1'b0;
			wrapFlag_r  <= 1'b0;
		end else begin
			if (loadPos_nxt || loadNeg_nxt) begin
				readyFlag_r <= 1'b1; // RULE8
			end else if (readyClear) begin
				readyFlag_r <= 1'b0;
			end
			if (wrapSet) begin
				wrapFlag_r <= 1'b1; // RULE10 RULE12
			end else if (wrapClear) begin
				wrapFlag_r <= 1'b0;
			end
		end
	end

	// ****************************************
	// Event status, mask and interrupt
	// ****************************************
	assign evtSet = {discard, wrapSet, loadPos_nxt || loadNeg_nxt};

	// Sticky events clear by writing one; a set in the same cycle wins.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			evtStatus_r <= pulse_timer_pkg::EVT_RESET;
			evtMask_r   <= pulse_timer_pkg::EVT_RESET;
		end else begin
			if (wrStrobe && wrByte0
			    && wrAddr == pulse_timer_pkg::EVT_STATUS_OFFSET) begin
				evtStatus_r <= (evtStatus_r & ~wrData[2:0]) | evtSet;
			end else begin
				evtStatus_r <= evtStatus_r | evtSet;
			end
			if (wrStrobe && wrByte0
			    && wrAddr == pulse_timer_pkg::EVT_MASK_OFFSET) begin
				evtMask_r <= wrData[2:0];
			end
		end
	end

	// The master enable gates every source, so it alone can silence the line.
	assign irq_nxt = irqMaster_r // RULE3
	                 && ((readyIrqEn_r && readyFlag_r) // RULE4
	                     || (ovfIrqEn_r && wrapFlag_r) // RULE5
	                     || |(evtStatus_r & evtMask_r)); // RULE14

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= irq_nxt;
		end
	end

	// ****************************************
	// Read decode
	// ****************************************
	// The soft reset bit has no storage and always reads back as zero.
	assign csView = {timerEnable, irqMaster_r, readyIrqEn_r, ovfIrqEn_r,
	                 1'b0, firstLoadEn_r, readyFlag_r, wrapFlag_r}; // RULE6

	always_comb begin
		rdData = 32'h0000_0000;
		rdErr  = 1'b0;
		unique case (rdAddr)
			pulse_timer_pkg::CS_OFFSET:         rdData[7:0] = csView;
			pulse_timer_pkg::EVT_STATUS_OFFSET: rdData[2:0] = evtStatus_r;
			pulse_timer_pkg::EVT_MASK_OFFSET:   rdData[2:0] = evtMask_r;
			default:                            rdErr = 1'b1;
		endcase
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence firstEdge;
		firstPending_r && timerEnable && captureEdge && !softReq;
	endsequence
	sequence softThenIdle;
		softReq ##1 (softReset && !timerEnable && !readyFlag_r);
	endsequence

	a_enable_write: assert property ( // RULE1
		csWrite && !softReq |=> timerEnable == $past(wrData[7]))
		else $error("Enable bit did not follow the write.");
	a_master_gate: assert property ( // RULE3
		!irqMaster_r |=> !irq)
		else $error("Interrupt raised with master enable clear.");
	a_ready_irq: assert property ( // RULE4
		irqMaster_r && readyIrqEn_r && readyFlag_r |=> irq)
		else $error("Ready interrupt missing.");
	a_wrap_irq: assert property ( // RULE5
		irqMaster_r && ovfIrqEn_r && wrapFlag_r |=> irq)
		else $error("Overflow interrupt missing.");
	a_irq_quiet: assert property ( // RULE14
		!(readyIrqEn_r && readyFlag_r) && !(ovfIrqEn_r && wrapFlag_r)
		&& (evtStatus_r & evtMask_r) == 3'h0 |=> !irq)
		else $error("Interrupt raised with no enabled source.");
	a_soft_clear: assert property ( // RULE15
		softReq |-> softThenIdle ##0 (csView == 8'h00))
		else $error("Soft reset left register bits set.");
	// A ready flag left over from an earlier run may stand; it must not rise.
	a_first_discard: assert property ( // RULE7
		firstEdge ##0 !firstLoadEn_r
		|=> !loadPositive && !loadNegative && !$rose(readyFlag_r))
		else $error("First value was loaded while loading is off.");
	a_first_level: assert property ( // RULE13
		firstEdge ##0 firstLoadEn_r
		|=> loadPositive == $past(inputLevel)
		    && loadNegative == !$past(inputLevel))
		else $error("First value went to the wrong width register.");
	a_ready_set: assert property ( // RULE8
		takeValue |=> readyFlag_r ##0 (loadPositive || loadNegative))
		else $error("Ready flag not set after an update.");
	a_ready_needs_read: assert property ( // RULE9
		$fell(readyFlag_r) && !$past(softReq) |-> $past(readArmed_r))
		else $error("Ready flag cleared without an earlier read.");
	a_wrap_wins: assert property ( // RULE12
		wrapSet |=> wrapFlag_r)
		else $error("Overflow flag lost a wrap.");
	a_wrap_clear: assert property ( // RULE11
		wrapClear && !wrapSet && !softReq |=> !wrapFlag_r)
		else $error("Overflow flag did not clear on write of zero.");
endmodule : pulse_width_timer_ctrl_status

// ==== test/pulse_width_timer_ctrl_status_bench.sv ====
// Self-checking bench for the pulse width timer control and status slice.
`timescale 1ns/1ps
module pulse_width_timer_ctrl_status_bench;
	// ****************************************
	// Signals and counters
	// ****************************************
	logic        ref_clk, rst;
	logic [3:0]  awaddr, araddr, wstrb;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic        captureEdge, wrapPulse, raceWrap, race, inputLevel;
	logic        timerEnable, softReset, loadPositive, loadNegative, irq;
	int          error_cnt, tests_run, posCnt, negCnt, srCnt;
	logic [1:0]  resp;
	logic [31:0] rd;

	pulse_width_timer_ctrl_status pulse_width_timer_ctrl_status_inst (
		.ref_clk(ref_clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.captureEdge(captureEdge), .counterWrap(wrapPulse | raceWrap),
		.inputLevel(inputLevel), .timerEnable(timerEnable),
		.softReset(softReset), .loadPositive(loadPositive),
		.loadNegative(loadNegative), .irq(irq));

	// Clock of 5 ns; pulse counters let checks ignore exact pulse timing.
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (rst) begin
			posCnt   <= 0;
			negCnt   <= 0;
			srCnt    <= 0;
			raceWrap <= 1'b0;
		end else begin
			posCnt <= posCnt + int'(loadPositive);
			negCnt <= negCnt + int'(loadNegative);
			srCnt  <= srCnt + int'(softReset);
			// A wrap lands on the very edge that applies a taken write.
			raceWrap <= race && awvalid && awready && wvalid && wready;
		end
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test

	task automatic hang;
		error_cnt++;
		$display("ERROR t=%0t bus wait ran out", $time);
		stop_test();
	endtask : hang

	// Address and data are offered together and each is released when taken.
	task automatic axiWrite(input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= d;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge ref_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (n == 50) hang();
		resp = bresp;
		bready <= 1'b0;
	endtask : axiWrite

	task automatic axiRead(input logic [3:0] a);
		int n;
		@(posedge ref_clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge ref_clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (n == 50) hang();
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : axiRead

	task automatic rdChk(input logic [3:0] a, input logic [31:0] exp);
		axiRead(a);
		check(rd, exp);
	endtask : rdChk

	// One-cycle measured edge, then time for the load pulse to land.
	task automatic capture(input logic lvl);
		@(posedge ref_clk);
		captureEdge <= 1'b1;
		inputLevel  <= lvl;
		@(posedge ref_clk);
		captureEdge <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask : capture

	task automatic wrap;
		@(posedge ref_clk);
		wrapPulse <= 1'b1;
		@(posedge ref_clk);
		wrapPulse <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask : wrap

	// Interrupt output lags its flags by one edge, so settle first.
	task automatic irqChk(input logic exp);
		repeat (3) @(posedge ref_clk);
		check({31'h0, irq}, {31'h0, exp});
	endtask : irqChk

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic testIdle;
		rdChk(pulse_timer_pkg::CS_OFFSET, 32'h0000_0000);
		rdChk(pulse_timer_pkg::EVT_STATUS_OFFSET, 32'h0000_0000);
		axiRead(4'hC);
		check({30'h0, resp}, {30'h0, pulse_timer_pkg::RESP_SLVERR});
		check(rd, 32'h0000_0000);
		axiWrite(4'hC, 32'h0000_00FF);
		check({30'h0, resp}, {30'h0, pulse_timer_pkg::RESP_SLVERR});
		// With byte lane 0 off the write is answered but changes nothing.
		wstrb <= 4'hE;
		axiWrite(pulse_timer_pkg::CS_OFFSET, 32'h0000_00FF);
		wstrb <= 4'hF;
		check({30'h0, resp}, {30'h0, pulse_timer_pkg::RESP_OKAY});
		rdChk(pulse_timer_pkg::CS_OFFSET, 32'h0000_0000);
		// Events while disabled must leave no trace.
		capture(1'b1);
		wrap();
		check(posCnt + negCnt, 0);
		rdChk(pulse_timer_pkg::CS_OFFSET, 32'h0000_0000);
		$display("Test idle done");
	endtask : testIdle

	task automatic testDiscard;
		// Configuration is set in the same write that enables.
		axiWrite(pulse_timer_pkg::CS_OFFSET, 32'h0000_0080);
		check({31'h0, timerEnable}, 32'h1);
		capture(1'b1);
		check(posCnt + negCnt, 0);
		rdChk(pulse_timer_pkg::EVT_STATUS_OFFSET, 32'h0000_0004);
		capture(1'b0);
		check(negCnt, 1);
		rdChk(pulse_timer_pkg::CS_OFFSET, 32'h0000_0082);
		$display("Test discard done");
	endtask : testDiscard

	task automatic testSoftReset;
		axiWrite(pulse_timer_pkg::CS_OFFSET, 32'h0000_0088);
		repeat (2) @(posedge ref_clk);
		check(srCnt, 1);
		rdChk(pulse_timer_pkg::CS_OFFSET, 32'h0000_0000);
		axiWrite(pulse_timer_pkg::CS_OFFSET, 32'h0000_0084);
		capture(1'b1);
		check(posCnt, 1);
		rdChk(pulse_timer_pkg::CS_OFFSET, 32'h0000_0086);
		$display("Test soft reset done");
	endtask : testSoftReset

	task automatic testReady;
		// The read above armed the clear; a write of one disarms it.
		axiWrite(pulse_timer_pkg::CS_OFFSET, 32'h0000_0086);
		axiWrite(pulse_timer_pkg::CS_OFFSET, 32'h0000_0084);
		rdChk(pulse_timer_pkg::CS_OFFSET, 32'h0000_0086);
		axiWrite(pulse_timer_pkg::CS_OFFSET, 32'h0000_0084);
		rdChk(pulse_timer_pkg::CS_OFFSET, 32'h0000_0084);
		$display("Test ready done");
	endtask : testReady

	task automatic testWrap;
		wrap();
		rdChk(pulse_timer_pkg::CS_OFFSET, 32'h0000_0085);
		axiWrite(pulse_timer_pkg::CS_OFFSET, 32'h0000_0085);
		rdChk(pulse_timer_pkg::CS_OFFSET, 32'h0000_0085);
		race <= 1'b1;
		axiWrite(pulse_timer_pkg::CS_OFFSET, 32'h0000_0084);
		race <= 1'b0;
		rdChk(pulse_timer_pkg::CS_OFFSET, 32'h0000_0085);
		axiWrite(pulse_timer_pkg::CS_OFFSET, 32'h0000_0084);
		rdChk(pulse_timer_pkg::CS_OFFSET, 32'h0000_0084);
		$display("Test wrap done");
	endtask : testWrap

	task automatic testIrq;
		capture(1'b1);
		wrap();
		// Interrupt settings change only while the timer is stopped.
		axiWrite(pulse_timer_pkg::CS_OFFSET, 32'h0000_0007);
		axiWrite(pulse_timer_pkg::CS_OFFSET, 32'h0000_0037);
		irqChk(1'b0);
		axiWrite(pulse_timer_pkg::CS_OFFSET, 32'h0000_0067);
		irqChk(1'b1);
		axiRead(pulse_timer_pkg::CS_OFFSET);
		axiWrite(pulse_timer_pkg::CS_OFFSET, 32'h0000_0065);
		irqChk(1'b0);
		axiWrite(pulse_timer_pkg::CS_OFFSET, 32'h0000_0055);
		irqChk(1'b1);
		axiWrite(pulse_timer_pkg::CS_OFFSET, 32'h0000_0045);
		irqChk(1'b0);
		axiWrite(pulse_timer_pkg::CS_OFFSET, 32'h0000_0044);
		// Event path: loads were recorded, unmask them, then clear.
		axiWrite(pulse_timer_pkg::EVT_MASK_OFFSET, 32'h0000_0001);
		irqChk(1'b1);
		axiWrite(pulse_timer_pkg::EVT_STATUS_OFFSET, 32'h0000_0007);
		irqChk(1'b0);
		rdChk(pulse_timer_pkg::EVT_STATUS_OFFSET, 32'h0000_0000);
		rdChk(pulse_timer_pkg::EVT_MASK_OFFSET, 32'h0000_0001);
		$display("Test interrupt done");
	endtask : testIrq

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rst         = 1'b1;
		awaddr      = 4'h0;
		awvalid     = 1'b0;
		wdata       = 32'h0000_0000;
		wstrb       = 4'hF;
		wvalid      = 1'b0;
		bready      = 1'b0;
		araddr      = 4'h0;
		arvalid     = 1'b0;
		rready      = 1'b0;
		captureEdge = 1'b0;
		wrapPulse   = 1'b0;
		race        = 1'b0;
		inputLevel  = 1'b0;
		error_cnt   = 0;
		tests_run   = 0;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		testIdle();
		testDiscard();
		testSoftReset();
		testReady();
		testWrap();
		testIrq();
		stop_test();
	end
endmodule : pulse_width_timer_ctrl_status_bench
